// *** ccp_controller.sv ***
// Purpose: Configuration controller: flash bus cycles, page select, power-on delay, config clock and data.
// Assumes: 50 MHz ref_clk, synchronous active-low rst_b, APB slave with zero wait states.
// Notes: All pin inputs pass two flip-flops; flash strobes decode straight from the state register.
// How it works
// [R1] The bus owner holds flash read enable low throughout each read cycle.
// [R2] Each flash write pulses write strobe low; flash latches on its rising edge.
// [R3] The controller has no drive onto the flash write-protect input.
// [R4] Flash ready/busy is not connected; software polls status for completion.
// [R5] Flash is used in sixteen-bit word mode, byte select held high.
// [R6] Three-bit page select, bit 2 MSB, picks one of eight pages; zero default.
// [R7] An optional external clock input can source the configuration clock.
// [R8] Power-on delay lasts 100 ms with select low, 2 ms with select high.
// [R9] A four-signal JTAG port carries TDI, TDO, TCK and TMS.
// [R10] Configuration runs only with strap low at 0 and strap high at 1.
// [R11] Flash chip enable is low only during cycles; high means standby.
// [R12] The open-drain status line is held low until the delay expires.
// [R13] Configuration clock is an output; data is stable on its rising edge.
// [R14] Page select is latched at sequence start and held for the sequence.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "ccp_map.svh"

module ccp_controller #(
   parameter int unsigned PorLongCycles = `CCP_POR_LONG_MS * `CCP_CLK_KHZ,
   parameter int unsigned PorShortCycles = `CCP_POR_SHORT_MS * `CCP_CLK_KHZ
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash bus.
   output logic [20:0] flashAddr,
   input wire logic [15:0] flashDqIn,
   output logic [15:0] flashDqOut,
   output logic flashDqOe_b,
   output logic flashCe_b,
   output logic flashOe_b,
   output logic flashWe_b,
   output logic flashByte_b,
   // Straps and selects.
   input wire logic [2:0] page_select,
   input wire logic reset_delay_select,
   input wire logic test_strap_low,
   input wire logic test_strap_high,
   input wire logic external_clock_in,
   // Open-drain status line.
   input wire logic statusIn,
   output logic statusOut,
   output logic statusOe_b,
   // Configuration output.
   output logic config_clock_out,
   output logic configData,
   // JTAG pins.
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [23:0] syncA_ff;
   logic [23:0] syncB_ff;
   logic extPrev_ff;
   wire logic [15:0] dqSync = syncB_ff[23:8];
   wire logic [2:0] pageSync = syncB_ff[7:5];
   wire logic extSync = syncB_ff[4];
   wire logic lineHigh = syncB_ff[3];
   wire logic delaySel = syncB_ff[2];
   wire logic strapNormal = !syncB_ff[1] && syncB_ff[0]; // R10

   // Two-stage synchronisers for every pin input.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         syncA_ff <= 24'h000000;
         syncB_ff <= 24'h000000;
         extPrev_ff <= 1'b0;
      end else begin
         syncA_ff <= {flashDqIn, page_select, external_clock_in, statusIn, reset_delay_select,
                      test_strap_low, test_strap_high};
         syncB_ff <= syncA_ff;
         extPrev_ff <= extSync;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [22:0] porCnt_ff;
   logic porDone_ff;
   wire logic [22:0] porTarget = delaySel ? 23'(PorShortCycles) : 23'(PorLongCycles);

   // Power-on delay counter; the status line stays low until it expires.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         porCnt_ff <= 23'h000000;
         porDone_ff <= 1'b0;
      end else if (!porDone_ff) begin
         porCnt_ff <= porCnt_ff + 23'h000001;
         porDone_ff <= (porCnt_ff + 23'h000001 >= porTarget); // R8
      end
   end

   assign statusOut = 1'b0;
   assign statusOe_b = porDone_ff; // R12

   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [31:0] rdMux;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic extClk_ff;
   logic [7:0] clkDiv_ff;
   logic [20:0] swAddr_ff;
   logic [15:0] swWdata_ff;
   logic [15:0] cfgLen_ff;
   logic swRd_ff;
   logic swWr_ff;
   logic swStart_ff;
   logic [31:0] statusWord;
   wire logic setupPh = psel && !penable;
   wire logic wrAcc = psel && penable && pwrite;
   wire logic hitCtrl = (paddr == `CCP_OFF_CTRL);
   wire logic hitStatus = (paddr == `CCP_OFF_STATUS);
   wire logic hitAddr = (paddr == `CCP_OFF_ADDR);
   wire logic hitWdata = (paddr == `CCP_OFF_WDATA);
   wire logic hitRdata = (paddr == `CCP_OFF_RDATA);
   wire logic hitLen = (paddr == `CCP_OFF_CFGLEN);
   wire logic mapped = hitCtrl || hitStatus || hitAddr || hitWdata || hitRdata || hitLen;
   wire logic ctrlWr = wrAcc && hitCtrl;

   assign pready = 1'b1;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   ccp_pkg::ccp_fl_state_t flState_ff;
   ccp_pkg::ccp_cf_state_t cfState_ff;
   logic [2:0] flCnt_ff;
   logic [20:0] flashAddr_ff;
   logic [15:0] flashDqOut_ff;
   logic [15:0] rdData_ff;
   logic flDone_ff;
   logic [2:0] page_ff;
   logic [20:0] cfgAddr_ff;
   logic [15:0] cfgWord_ff;
   logic [15:0] wordsLeft_ff;
   logic [3:0] bitIdx_ff;
   logic cfgClk_ff;
   logic cfgData_ff;
   logic cfgDone_ff;
   logic autoUsed_ff;
   logic [7:0] divCnt_ff;
   logic tapResetSeen;
   wire logic flIdle = (flState_ff == ccp_pkg::FL_IDLE);
   wire logic cfgReq = (cfState_ff == ccp_pkg::CF_FETCH);
   wire logic swRdTake = flIdle && !cfgReq && swRd_ff;
   wire logic swWrTake = flIdle && !cfgReq && !swRd_ff && swWr_ff;
   wire logic autoStart = porDone_ff && lineHigh && !autoUsed_ff;
   wire logic startReq = swStart_ff || autoStart;
   wire logic cfgTake = (cfState_ff == ccp_pkg::CF_IDLE) && startReq && strapNormal && porDone_ff;
   wire logic divTick = (divCnt_ff == clkDiv_ff);
   wire logic extEdge = extSync ^ extPrev_ff;
   wire logic tick = extClk_ff ? extEdge : divTick; // R7

   // Status word assembled from live block state.
   always_comb begin
      statusWord = 32'h00000000;
      statusWord[`CCP_STAT_POR_DONE] = porDone_ff;
      statusWord[`CCP_STAT_FL_BUSY] = !flIdle || swRd_ff || swWr_ff; // R4
      statusWord[`CCP_STAT_CFG_BUSY] = (cfState_ff != ccp_pkg::CF_IDLE);
      statusWord[`CCP_STAT_CFG_DONE] = cfgDone_ff;
      statusWord[`CCP_STAT_STRAP_OK] = strapNormal;
      statusWord[`CCP_STAT_PAGE_MSB:`CCP_STAT_PAGE_LSB] = page_ff;
      statusWord[`CCP_STAT_DELAY_SEL] = delaySel;
      statusWord[`CCP_STAT_LINE_HIGH] = lineHigh;
      statusWord[`CCP_STAT_TAP_RESET] = tapResetSeen;
   end

   // Read data selection for the addressed register.
   assign rdMux = hitCtrl ? {16'h0000, clkDiv_ff, 4'h0, extClk_ff, 3'h0} :
                  hitStatus ? statusWord :
                  hitAddr ? {11'h000, swAddr_ff} :
                  hitWdata ? {16'h0000, swWdata_ff} :
                  hitRdata ? {16'h0000, rdData_ff} :
                  hitLen ? {16'h0000, cfgLen_ff} : 32'h00000000;

   // APB register file; read data and error are captured in the setup phase.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
         extClk_ff <= 1'b0;
         clkDiv_ff <= `CCP_DIV_RESET;
         swAddr_ff <= 21'h000000;
         swWdata_ff <= 16'h0000;
         cfgLen_ff <= `CCP_CFGLEN_RESET;
      end else begin
         if (setupPh) begin
            prdata_ff <= rdMux;
            pslverr_ff <= !mapped;
         end
         if (ctrlWr) begin
            extClk_ff <= pwdata[`CCP_CTRL_EXT_CLK];
            clkDiv_ff <= pwdata[`CCP_CTRL_DIV_MSB:`CCP_CTRL_DIV_LSB];
         end
         if (wrAcc && hitAddr) begin
            swAddr_ff <= pwdata[20:0];
         end
         if (wrAcc && hitWdata) begin
            swWdata_ff <= pwdata[15:0];
         end
         if (wrAcc && hitLen) begin
            cfgLen_ff <= pwdata[15:0];
         end
      end
   end

   // Pending software requests; a new request wins over the clear in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         swRd_ff <= 1'b0;
         swWr_ff <= 1'b0;
         swStart_ff <= 1'b0;
      end else begin
         swRd_ff <= (ctrlWr && pwdata[`CCP_CTRL_RD_GO]) || (swRd_ff && !swRdTake);
         swWr_ff <= (ctrlWr && pwdata[`CCP_CTRL_WR_GO]) || (swWr_ff && !swWrTake);
         swStart_ff <= (ctrlWr && pwdata[`CCP_CTRL_CFG_GO]) || (swStart_ff && !cfgTake);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Flash strobes decoded from the cycle sequencer.
   assign flashAddr = flashAddr_ff;
   assign flashDqOut = flashDqOut_ff;
   assign flashCe_b = flIdle; // R11
   assign flashOe_b = (flState_ff != ccp_pkg::FL_READ); // R1
   assign flashWe_b = (flState_ff != ccp_pkg::FL_WRITE); // R2
   assign flashDqOe_b = !((flState_ff == ccp_pkg::FL_WRITE) || (flState_ff == ccp_pkg::FL_HOLD));
   assign flashByte_b = 1'b1; // R5

   // Flash cycle sequencer; configuration fetches take priority over software.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         flState_ff <= ccp_pkg::FL_IDLE;
         flCnt_ff <= 3'h0;
         flashAddr_ff <= 21'h000000;
         flashDqOut_ff <= 16'h0000;
         rdData_ff <= 16'h0000;
         flDone_ff <= 1'b0;
      end else begin
         flDone_ff <= 1'b0;
         case (flState_ff)
            ccp_pkg::FL_IDLE: begin
               flCnt_ff <= 3'h0;
               if (cfgReq) begin
                  flashAddr_ff <= cfgAddr_ff;
                  flState_ff <= ccp_pkg::FL_READ;
               end else if (swRdTake) begin
                  flashAddr_ff <= swAddr_ff;
                  flState_ff <= ccp_pkg::FL_READ;
               end else if (swWrTake) begin
                  flashAddr_ff <= swAddr_ff;
                  flashDqOut_ff <= swWdata_ff;
                  flState_ff <= ccp_pkg::FL_WRITE;
               end
            end
            ccp_pkg::FL_READ: begin
               flCnt_ff <= flCnt_ff + 3'h1;
               if (flCnt_ff == `CCP_FL_RD_CYC) begin
                  rdData_ff <= dqSync; // R5
                  flDone_ff <= 1'b1;
                  flState_ff <= ccp_pkg::FL_IDLE;
               end
            end
            ccp_pkg::FL_WRITE: begin
               flCnt_ff <= flCnt_ff + 3'h1;
               if (flCnt_ff == `CCP_FL_WE_CYC) begin
                  flState_ff <= ccp_pkg::FL_HOLD; // R2
               end
            end
            ccp_pkg::FL_HOLD: begin
               flState_ff <= ccp_pkg::FL_IDLE;
            end
            default: begin
               flState_ff <= ccp_pkg::FL_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   assign config_clock_out = cfgClk_ff; // R13
   assign configData = cfgData_ff;

   // Clock divider for the internal configuration clock source.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         divCnt_ff <= 8'h00;
      end else begin
         divCnt_ff <= divTick ? 8'h00 : divCnt_ff + 8'h01;
      end
   end

   // Configuration streamer: fetch a word, shift it out LSB first, repeat.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cfState_ff <= ccp_pkg::CF_IDLE;
         page_ff <= 3'h0;
         cfgAddr_ff <= 21'h000000;
         cfgWord_ff <= 16'h0000;
         wordsLeft_ff <= 16'h0000;
         bitIdx_ff <= 4'h0;
         cfgClk_ff <= 1'b0;
         cfgData_ff <= 1'b0;
         cfgDone_ff <= 1'b0;
         autoUsed_ff <= 1'b0;
      end else begin
         if (autoStart) begin
            autoUsed_ff <= 1'b1;
         end
         case (cfState_ff)
            ccp_pkg::CF_IDLE: begin
               if (cfgTake) begin
                  page_ff <= pageSync; // R14
                  cfgAddr_ff <= {pageSync, {`CCP_PAGE_SHIFT{1'b0}}}; // R6
                  wordsLeft_ff <= cfgLen_ff;
                  cfgDone_ff <= 1'b0;
                  cfState_ff <= (cfgLen_ff == 16'h0000) ? ccp_pkg::CF_DONE : ccp_pkg::CF_FETCH;
               end
            end
            ccp_pkg::CF_FETCH: begin
               if (flIdle) begin
                  cfState_ff <= ccp_pkg::CF_WAIT;
               end
            end
            ccp_pkg::CF_WAIT: begin
               if (flDone_ff) begin
                  cfgWord_ff <= rdData_ff;
                  cfgData_ff <= rdData_ff[0];
                  bitIdx_ff <= 4'h0;
                  cfgAddr_ff <= cfgAddr_ff + 21'h000001;
                  cfState_ff <= ccp_pkg::CF_SHIFT;
               end
            end
            ccp_pkg::CF_SHIFT: begin
               if (tick && !cfgClk_ff) begin
                  cfgClk_ff <= 1'b1; // R13
               end else if (tick) begin
                  cfgClk_ff <= 1'b0;
                  if (bitIdx_ff != 4'hf) begin
                     bitIdx_ff <= bitIdx_ff + 4'h1;
                     cfgData_ff <= cfgWord_ff[bitIdx_ff + 4'h1];
                  end else if (wordsLeft_ff == 16'h0001) begin
                     cfState_ff <= ccp_pkg::CF_DONE;
                  end else begin
                     wordsLeft_ff <= wordsLeft_ff - 16'h0001;
                     cfState_ff <= ccp_pkg::CF_FETCH;
                  end
               end
            end
            ccp_pkg::CF_DONE: begin
               cfgDone_ff <= 1'b1;
               cfState_ff <= ccp_pkg::CF_IDLE;
            end
            default: begin
               cfState_ff <= ccp_pkg::CF_IDLE;
            end
         endcase
      end
   end

   // JTAG port, held off until the power-on delay has expired.
   ccp_jtag_port u_jtag (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .enable(porDone_ff),
      .tckPin(tck),
      .tmsPin(tms),
      .tdiPin(tdi),
      .tdoPin(tdo),
      .tapResetSeen(tapResetSeen)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks kept beside the logic they guard.
   status_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
      !porDone_ff && (porCnt_ff + 23'h000002 < porTarget) |=> !statusOe_b)
      else $error("Status line released before the delay expired.");

   por_length_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R8
      $rose(porDone_ff) |-> porCnt_ff == $past(porTarget))
      else $error("Power-on delay did not match the selected length.");

   read_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
      $rose(flState_ff == ccp_pkg::FL_READ) |-> (!flashOe_b && !flashCe_b)[*6])
      else $error("Read enable dropped inside a read cycle.");

   write_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
      $rose(flashWe_b) |-> !flashCe_b && !flashDqOe_b && $stable(flashDqOut) && $stable(flashAddr))
      else $error("Write strobe rose without stable address and data.");

   word_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
      flashByte_b)
      else $error("Byte select left word mode.");

   ce_standby_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R11
      flashCe_b |-> flashOe_b && flashWe_b && flashDqOe_b)
      else $error("Flash strobe active while deselected.");

   page_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
      (cfState_ff != ccp_pkg::CF_IDLE) |=> $stable(page_ff) || $past(cfgTake))
      else $error("Page changed during a configuration sequence.");

   page_base_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
      cfgTake |=> cfgAddr_ff == {$past(pageSync), {`CCP_PAGE_SHIFT{1'b0}}})
      else $error("Configuration did not start at the page base.");

   strap_block_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
      (cfState_ff == ccp_pkg::CF_IDLE) && !strapNormal |=> cfState_ff == ccp_pkg::CF_IDLE)
      else $error("Configuration started with test straps set.");

   data_setup_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R13
      $rose(config_clock_out) |-> $stable(configData))
      else $error("Configuration data moved on a rising clock.");

   ext_source_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
      extClk_ff && !extEdge |=> $stable(config_clock_out))
      else $error("Configuration clock moved without an external edge.");

endmodule

// *** ccp_flash_model.sv ***
// Purpose: Behavioural flash array on the far side of the controller's flash bus.
// Assumes: Only the low four address bits select a word.
// Notes: Released data lines show the inverse of the stored word, never a held value.
`timescale 1ns/10ps

module ccp_flash_model (
   // Flash control and data.
   input wire logic [20:0] addr,
   input wire logic chipEnable_b,
   input wire logic readEnable_b,
   input wire logic writeStrobe_b,
   input wire logic [15:0] dqIn,
   output logic [15:0] dqOut
);
   logic [15:0] mem [16];

   // Fills the array with a known pattern.
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'h1111 * i[15:0];
      end
   end

   // Latches address and data on the rising edge of the write strobe while selected.
   always @(posedge writeStrobe_b) begin
      if (!chipEnable_b) begin
         mem[addr[3:0]] = dqIn;
      end
   end

   // Drives the word only while selected and read-enabled.
   always_comb dqOut = (!chipEnable_b && !readEnable_b) ? mem[addr[3:0]] : ~mem[addr[3:0]];
endmodule

// *** ccp_jtag_port.sv ***
// Purpose: Four-signal JTAG port with a one-bit bypass path, sampled on ref_clk.
// Assumes: TCK is far slower than ref_clk; all input pins pass two flip-flops first.
// Notes: The instruction set is not decoded here; only bypass and TMS reset tracking.
`timescale 1ns/10ps
`include "ccp_map.svh"

module ccp_jtag_port (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Gate from the power-on delay.
   input wire logic enable,
   // JTAG pins.
   input wire logic tckPin,
   input wire logic tmsPin,
   input wire logic tdiPin,
   output logic tdoPin,
   // Status.
   output logic tapResetSeen
);

   logic [2:0] syncA_ff;
   logic [2:0] syncB_ff;
   logic tckPrev_ff;
   logic bypass_ff;
   logic tdo_ff;
   logic [2:0] tmsHigh_ff;
   wire logic tckRise;
   wire logic tckFall;

   // Edges of the synchronised test clock.
   assign tckRise = syncB_ff[0] && !tckPrev_ff;
   assign tckFall = !syncB_ff[0] && tckPrev_ff;
   assign tdoPin = tdo_ff;
   assign tapResetSeen = (tmsHigh_ff == `CCP_TAP_RESET_TMS);

   // Synchronisers, bypass capture on TCK rise and TDO update on TCK fall.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         syncA_ff <= 3'h0;
         syncB_ff <= 3'h0;
         tckPrev_ff <= 1'b0;
         bypass_ff <= 1'b0;
         tdo_ff <= 1'b0;
         tmsHigh_ff <= 3'h0;
      end else begin
         syncA_ff <= {tdiPin, tmsPin, tckPin};
         syncB_ff <= syncA_ff;
         tckPrev_ff <= syncB_ff[0];
         if (enable && tckRise) begin
            bypass_ff <= syncB_ff[2]; // R9
            if (!syncB_ff[1]) begin
               tmsHigh_ff <= 3'h0;
            end else if (tmsHigh_ff != `CCP_TAP_RESET_TMS) begin
               tmsHigh_ff <= tmsHigh_ff + 3'h1;
            end
         end
         if (enable && tckFall) begin
            tdo_ff <= bypass_ff; // R9
         end
      end
   end

   // TDO moves only just after a falling test clock edge.
   tdo_timing_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
      $changed(tdoPin) |-> $past(tckFall) && $past(enable))
      else $error("TDO changed without a falling TCK.");

   // The bypass bit takes TDI on a rising test clock edge.
   bypass_path_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
      enable && tckRise |=> bypass_ff == $past(syncB_ff[2]))
      else $error("Bypass bit did not capture TDI.");

endmodule

// *** ccp_map.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the configuration controller.
// Assumes: 50 MHz ref_clk; APB byte addresses with one aligned 32-bit word per register.
// Notes: Definitions only; include by bare name.
`ifndef CCP_MAP_SVH
`define CCP_MAP_SVH

// Register byte offsets.
`define CCP_OFF_CTRL 8'h00
`define CCP_OFF_STATUS 8'h04
`define CCP_OFF_ADDR 8'h08
`define CCP_OFF_WDATA 8'h0c
`define CCP_OFF_RDATA 8'h10
`define CCP_OFF_CFGLEN 8'h14

// Control register fields.
`define CCP_CTRL_RD_GO 0
`define CCP_CTRL_WR_GO 1
`define CCP_CTRL_CFG_GO 2
`define CCP_CTRL_EXT_CLK 3
`define CCP_CTRL_DIV_LSB 8
`define CCP_CTRL_DIV_MSB 15

// Status register fields.
`define CCP_STAT_POR_DONE 0
`define CCP_STAT_FL_BUSY 1
`define CCP_STAT_CFG_BUSY 2
`define CCP_STAT_CFG_DONE 3
`define CCP_STAT_STRAP_OK 4
`define CCP_STAT_PAGE_LSB 5
`define CCP_STAT_PAGE_MSB 7
`define CCP_STAT_DELAY_SEL 8
`define CCP_STAT_LINE_HIGH 9
`define CCP_STAT_TAP_RESET 10

// Reset values.
`define CCP_DIV_RESET 8'h04
`define CCP_CFGLEN_RESET 16'h0100

// Timing: reset delays in milliseconds and the clock rate in kilohertz.
`define CCP_POR_LONG_MS 100
`define CCP_POR_SHORT_MS 2
`define CCP_CLK_KHZ 50000

// Flash strobe lengths in ref_clk cycles less one, and page size as an address shift.
`define CCP_FL_RD_CYC 3'h5
`define CCP_FL_WE_CYC 3'h3
`define CCP_PAGE_SHIFT 18
`define CCP_TAP_RESET_TMS 3'h5

`endif

// *** ccp_pkg.sv ***
// Purpose: Types shared by the configuration controller.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Constants live in ccp_map.svh.
package ccp_pkg;

   // Flash bus cycle sequencer states.
   typedef enum logic [1:0] {FL_IDLE, FL_READ, FL_WRITE, FL_HOLD} ccp_fl_state_t;

   // Configuration streaming states.
   typedef enum logic [2:0] {CF_IDLE, CF_FETCH, CF_WAIT, CF_SHIFT, CF_DONE} ccp_cf_state_t;

endpackage

// *** config_controller_pin_control_test.sv ***
// Purpose: Self-checking bench for the configuration controller.
// Assumes: Reset delays shortened to 40 and 200 cycles.
// Notes: The status line has a pull-up; the flash bus level is resolved here.
`timescale 1ns/10ps
`include "ccp_map.svh"

module config_controller_pin_control_test;
   logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, errLast, flashDqOe_b, flashCe_b, flashOe_b;
   logic flashWe_b, flashByte_b, statusOut, statusOe_b, config_clock_out, configData, tdo, tck, tdi, delaySel;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [20:0] flashAddr;
   logic tms, extClk;
   logic [15:0] flashDqOut, modelDq, cfgShift;
   logic [2:0] pageSel;
   int failures = 0;
   int n_checks = 0;
   int clockRises = 0;
   // Bus and open-drain line levels.
   wire logic [15:0] flashDq = flashDqOe_b ? modelDq : flashDqOut;
   wire logic statusLine = statusOe_b ? 1'b1 : statusOut;

   ccp_controller #(.PorLongCycles(200), .PorShortCycles(40)) i_dut (.ref_clk, .rst_b, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flashAddr, .flashDqIn(flashDq), .flashDqOut,
      .flashDqOe_b, .flashCe_b, .flashOe_b, .flashWe_b, .flashByte_b, .page_select(pageSel),
      .reset_delay_select(delaySel), .test_strap_low(1'b0), .test_strap_high(1'b1), .external_clock_in(extClk),
      .statusIn(statusLine), .statusOut, .statusOe_b, .config_clock_out, .configData, .tck, .tms,
      .tdi, .tdo);
   ccp_flash_model i_flash (.addr(flashAddr), .chipEnable_b(flashCe_b), .readEnable_b(flashOe_b),
      .writeStrobe_b(flashWe_b), .dqIn(flashDq), .dqOut(modelDq));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, configuration clock edge count and the serial data taken on each rising edge.
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge config_clock_out) begin
      clockRises++;
      cfgShift = {configData, cfgShift[15:1]};
   end

   // Compares one value and counts mismatches.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; holds the request until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      errLast = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Polls a status bit until it reaches a level.
   task automatic poll(input int b, input logic v);
      for (int i = 0; i < 200; i++) begin
         apb(1'b0, `CCP_OFF_STATUS, 32'h0);
         if (rd[b] === v) break;
      end
   endtask

   // Prints the counts and the verdict.
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Short reset delay holds the status line low, then releases it.
   task automatic test_por;
      @(posedge ref_clk);
      rst_b <= 1'b1;
      apb(1'b1, `CCP_OFF_CFGLEN, 32'h2);
      repeat (25) @(posedge ref_clk);
      chk(statusOe_b, 1'b0);
      repeat (20) @(posedge ref_clk);
      chk(statusOe_b, 1'b1);
      chk(flashByte_b, 1'b1);
      $display("test_por done");
   endtask

   // Auto configuration keeps the latched page and clocks out two words.
   task automatic test_config;
      repeat (10) @(posedge ref_clk);
      pageSel <= 3'h0;
      poll(`CCP_STAT_CFG_DONE, 1'b1);
      chk(rd[7:5], 3'h5);
      chk(rd[4], 1'b1);
      chk(clockRises, 32'd32);
      chk(cfgShift, 32'h1111);
      $display("test_config done");
   endtask

   // Flash write then read back through the strobes.
   task automatic test_flash;
      apb(1'b1, `CCP_OFF_ADDR, 32'h5);
      apb(1'b1, `CCP_OFF_WDATA, 32'hbeef);
      apb(1'b1, `CCP_OFF_CTRL, 32'h402);
      poll(`CCP_STAT_FL_BUSY, 1'b0);
      apb(1'b1, `CCP_OFF_CTRL, 32'h401);
      poll(`CCP_STAT_FL_BUSY, 1'b0);
      apb(1'b0, `CCP_OFF_RDATA, 32'h0);
      chk(rd, 32'hbeef);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      chk(errLast, 1'b1);
      $display("test_flash done");
   endtask

   // External clock source streams the new page; each pin edge is one half period.
   task automatic test_ext;
      apb(1'b1, `CCP_OFF_CTRL, 32'h40c);
      for (int i = 0; i < 80; i++) begin
         extClk <= ~extClk;
         repeat (4) @(posedge ref_clk);
      end
      poll(`CCP_STAT_CFG_DONE, 1'b1);
      chk(rd[7:5], 3'h0);
      chk(clockRises, 32'd64);
      $display("test_ext done");
   endtask

   // Bypass path carries TDI to TDO across one test clock.
   task automatic test_jtag;
      for (int v = 4; v >= 0; v--) begin
         tdi <= v[0];
         tck <= 1'b1;
         repeat (8) @(posedge ref_clk);
         tck <= 1'b0;
         repeat (8) @(posedge ref_clk);
         chk(tdo, v[0]);
      end
      apb(1'b0, `CCP_OFF_STATUS, 32'h0);
      chk(rd[`CCP_STAT_TAP_RESET], 1'b1);
      $display("test_jtag done");
   endtask

   // Main sequence.
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tck = 1'b0;
      tdi = 1'b0;
      tms = 1'b1;
      extClk = 1'b0;
      delaySel = 1'b1;
      pageSel = 3'h5;
      repeat (5) @(posedge ref_clk);
      test_por;
      test_config;
      test_flash;
      test_ext;
      test_jtag;
      finish_test;
   end

   // Watchdog against a hang.
   initial begin
      #200us;
      failures++;
      finish_test;
   end
endmodule
